// file: hw/iac_buffer_ram.sv
// one sample buffer: simple dual port memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module iac_buffer_ram
	import iac_pkg::*;
(
	// clock
	input  wire logic                      core_clk,
	// write port
	input  wire logic                      we,
	input  wire logic [iac_pkg::BUF_AW-1:0] waddr,
	input  wire logic [iac_pkg::DATA_W-1:0] wdata,
	// read port
	input  wire logic [iac_pkg::BUF_AW-1:0] raddr,
	output logic      [iac_pkg::DATA_W-1:0] rdata
);
	logic [DATA_W-1:0] mem [BUF_DEPTH];

	// write-through when both ports meet, so a word pushed into an empty buffer is seen at once
	always_ff @(posedge core_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= (we && waddr == raddr) ? wdata : mem[raddr];
	end
endmodule : iac_buffer_ram
`default_nettype wire

// file: hw/iac_pkg.sv
// shared constants, register map and state types of the converter sequencer
package iac_pkg;

	// timing; cycle counts derived from the nanosecond figures and the core clock period
	localparam int          CLK_NS    = 5;
	localparam int          CH_NS     = 10000; // one channel conversion, also least dac update
	localparam int          FILT_NS   = 1000;  // shortest pulse the deglitch filter passes
	localparam int          CH_CYC    = (CH_NS + CLK_NS - 1) / CLK_NS;
	localparam int          FILT_CYC  = (FILT_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [10:0] CH_LAST   = 11'(CH_CYC - 1);
	localparam logic [7:0]  FILT_LAST = 8'(FILT_CYC - 1);

	// data paths and buffers
	localparam int          DATA_W    = 16;
	localparam int          BUF_AW    = 10;
	localparam int          BUF_DEPTH = 1024;
	localparam logic [10:0] BUF_FULL  = 11'h400;
	localparam logic [10:0] AO_PAIR   = 11'h002;
	localparam int          ADDR_W    = 8;

	// register byte offsets
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_AI_CFG  = 8'h04;
	localparam logic [7:0] REG_AO_CFG  = 8'h08;
	localparam logic [7:0] REG_PIN_CFG = 8'h0C;
	localparam logic [7:0] REG_AI_INTV = 8'h10;
	localparam logic [7:0] REG_AO_INTV = 8'h14;
	localparam logic [7:0] REG_AI_NUM  = 8'h18;
	localparam logic [7:0] REG_AO_NUM  = 8'h1C;
	localparam logic [7:0] REG_STATUS  = 8'h20;
	localparam logic [7:0] REG_MASK    = 8'h24;
	localparam logic [7:0] REG_AI_LVL  = 8'h28;
	localparam logic [7:0] REG_AI_DATA = 8'h2C;
	localparam logic [7:0] REG_AO_DATA = 8'h30;
	localparam logic [7:0] REG_AO_LVL  = 8'h34;

	// control command bits (write-only pulses)
	localparam int CMD_AI_START = 0;
	localparam int CMD_AI_STOP  = 1;
	localparam int CMD_AO_START = 2;
	localparam int CMD_AO_STOP  = 3;

	// path configuration fields
	localparam int         CFG_SYNC     = 0;
	localparam int         CFG_EXTSTART = 1;
	localparam int         CFG_STOP_LSB = 2;
	localparam int         CFG_CHN_LSB  = 4;
	localparam logic [1:0] STOP_COUNT   = 2'h0;
	localparam logic [1:0] STOP_EXT     = 2'h1;

	// control pin indices; edge select at index, filter enable at index + offset
	localparam int PIN_AI_START  = 0;
	localparam int PIN_AI_STOP   = 1;
	localparam int PIN_AI_CLK    = 2;
	localparam int PIN_AO_START  = 3;
	localparam int PIN_AO_STOP   = 4;
	localparam int PIN_AO_CLK    = 5;
	localparam int PIN_N         = 6;
	localparam int PIN_FILT_LSB  = 8;

	// sticky flags and busy bits in the status register
	localparam int FLAG_AI_OVF = 0;
	localparam int FLAG_AO_UNF = 1;
	localparam int FLAG_AI_END = 2;
	localparam int FLAG_AO_END = 3;
	localparam int STAT_AI_BUSY = 8;
	localparam int STAT_AO_BUSY = 9;

	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {AI_IDLE, AI_ARM, AI_RUN, AI_CONV} iac_ai_state_t;
	typedef enum logic [2:0] {AO_IDLE, AO_ARM, AO_RUN, AO_CH0, AO_GAP, AO_CH1} iac_ao_state_t;

endpackage : iac_pkg

// file: hw/iac_sequencer.sv
// converter sequencer: axi4-lite registers, pin filters, input scan and output update paths
`timescale 1ns/1ps
`default_nettype none
module iac_sequencer
	import iac_pkg::*;
(
	// clock and reset
	input  wire logic                        core_clk,
	input  wire logic                        reset,
	// axi4-lite write address and data
	input  wire logic [iac_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	// axi4-lite write response
	output logic      [1:0]                  s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	// axi4-lite read
	input  wire logic [iac_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic      [31:0]                 s_axi_rdata,
	output logic      [1:0]                  s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// external control pins, asynchronous
	input  wire logic                        aiStartPin,
	input  wire logic                        aiStopPin,
	input  wire logic                        aiClkPin,
	input  wire logic                        aoStartPin,
	input  wire logic                        aoStopPin,
	input  wire logic                        aoClkPin,
	// input converter
	output logic                             adcConvert,
	output logic      [2:0]                  adcChannel,
	input  wire logic [iac_pkg::DATA_W-1:0]  adcData,
	// output converter
	output logic                             dacLoad,
	output logic                             dacChannel,
	output logic      [iac_pkg::DATA_W-1:0]  dacData,
	// interrupt
	output logic                             intaReq
);
	import iac_pkg::*;

	typedef struct packed {
		logic                   awready, wready, bvalid, arready, rvalid;
		logic                   awDone, wDone;
		logic [ADDR_W-1:0]      awAddr;
		logic [31:0]            wData;
		logic [3:0]             wStrb;
		logic [1:0]             bresp, rresp;
		logic [31:0]            rdata;
		logic [31:0]            aiCfg, aoCfg, pinCfg, aiIntv, aoIntv, aiNum, aoNum;
		logic [3:0]             flags, mask;
		logic [PIN_N-1:0]       s1, s2, filt, prev;
		logic [PIN_N-1:0][7:0]  fcnt;
		iac_ai_state_t          aiSt;
		iac_ao_state_t          aoSt;
		logic [31:0]            aiTmr, aoTmr, aiCnt, aoCnt;
		logic [10:0]            aiSlot, aoHold;
		logic [2:0]             aiCh;
		logic [BUF_AW-1:0]      aiWp, aiRp, aoWp, aoRp;
		logic [10:0]            aiLvl, aoLvl;
		logic                   adcConvert, dacLoad, dacChannel, irq;
		logic [2:0]             adcChannel;
		logic [DATA_W-1:0]      dacData;
	} iac_state_t;

	iac_state_t        r;
	iac_state_t        n;
	logic [DATA_W-1:0] aiMemRd;
	logic [DATA_W-1:0] aoMemRd;
	logic              aiPush;
	logic              aiPop;
	logic              aoPush;
	logic              aoPop;
	logic [DATA_W-1:0] aoWData;

	// byte-lane merge for register writes
	function automatic logic [31:0] iacMerge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] st);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (st[b]) begin
				res[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return res;
	endfunction : iacMerge

	// true when the sample just finished is the last one of a counted run
	function automatic logic iacCountDone(input logic [31:0] cfg, input logic [31:0] cnt,
			input logic [31:0] num);
		return cfg[CFG_STOP_LSB +: 2] == STOP_COUNT && 32'(cnt + 32'h1) == num;
	endfunction : iacCountDone

	// next interval timer value; expiry is a sampling instant
	function automatic logic [31:0] iacTimer(input logic [31:0] tmr, input logic [31:0] intv);
		return (tmr == 32'h0) ? intv : 32'(tmr - 32'h1);
	endfunction : iacTimer

	iac_buffer_ram aiBuf (
		.core_clk (core_clk),
		.we       (aiPush),
		.waddr    (r.aiWp),
		.wdata    (adcData),
		.raddr    (r.aiRp),
		.rdata    (aiMemRd)
	);

	iac_buffer_ram aoBuf (
		.core_clk (core_clk),
		.we       (aoPush),
		.waddr    (r.aoWp),
		.wdata    (aoWData),
		.raddr    (r.aoRp),
		.rdata    (aoMemRd)
	);

	// whole next state of the block
	always_comb begin
		logic [PIN_N-1:0] edg;
		logic [3:0]       cmd;
		logic [3:0]       clr;
		logic [3:0]       fset;
		logic             aiTick;
		logic             aoTick;
		logic             aiStop;
		logic             aoStop;
		logic             doWr;
		edg = '0;
		cmd = '0;
		clr = '0;
		fset = '0;
		aiTick = 1'b0;
		aoTick = 1'b0;
		aiStop = 1'b0;
		aoStop = 1'b0;
		doWr = 1'b0;
		n = r;
		aiPush = 1'b0;
		aiPop = 1'b0;
		aoPush = 1'b0;
		aoPop = 1'b0;
		aoWData = '0;
		n.adcConvert = 1'b0;
		n.dacLoad = 1'b0;

		// pins: two-flop synchroniser, then filter reads only the second stage
		n.s1 = {aoClkPin, aoStopPin, aoStartPin, aiClkPin, aiStopPin, aiStartPin};
		n.s2 = r.s1;
		for (int i = 0; i < PIN_N; i++) begin
			if (!r.pinCfg[PIN_FILT_LSB + i] || r.s2[i] == r.filt[i]) begin
				n.fcnt[i] = '0;
				n.filt[i] = r.s2[i];
			end else if (r.fcnt[i] == FILT_LAST) begin
				n.fcnt[i] = '0;
				n.filt[i] = r.s2[i];
			end else begin
				n.fcnt[i] = 8'(r.fcnt[i] + 8'h1);
			end
		end
		n.prev = r.filt;
		// select bit set means falling edge is active
		edg = (r.pinCfg[PIN_N-1:0] & r.prev & ~r.filt)
			| (~r.pinCfg[PIN_N-1:0] & ~r.prev & r.filt);

		// write channel: address and data taken in either order
		if (r.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (s_axi_awvalid && r.awready) begin
			n.awDone = 1'b1;
			n.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && r.wready) begin
			n.wDone = 1'b1;
			n.wData = s_axi_wdata;
			n.wStrb = s_axi_wstrb;
		end
		doWr = n.awDone && n.wDone && !r.bvalid;
		if (doWr) begin
			n.awDone = 1'b0;
			n.wDone = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = RESP_OKAY;
			case (n.awAddr)
				REG_CTRL:    cmd = n.wData[3:0] & {4{n.wStrb[0]}};
				REG_AI_CFG:  n.aiCfg = iacMerge(r.aiCfg, n.wData, n.wStrb);
				REG_AO_CFG:  n.aoCfg = iacMerge(r.aoCfg, n.wData, n.wStrb);
				REG_PIN_CFG: n.pinCfg = iacMerge(r.pinCfg, n.wData, n.wStrb);
				REG_AI_INTV: n.aiIntv = iacMerge(r.aiIntv, n.wData, n.wStrb);
				REG_AO_INTV: n.aoIntv = iacMerge(r.aoIntv, n.wData, n.wStrb);
				REG_AI_NUM:  n.aiNum = iacMerge(r.aiNum, n.wData, n.wStrb);
				REG_AO_NUM:  n.aoNum = iacMerge(r.aoNum, n.wData, n.wStrb);
				REG_STATUS:  clr = n.wData[3:0] & {4{n.wStrb[0]}};
				REG_MASK:    n.mask = 4'(iacMerge({28'h0, r.mask}, n.wData, n.wStrb));
				REG_AO_DATA: begin
					// a word written into a full buffer is dropped
					aoWData = n.wData[DATA_W-1:0];
					aoPush = r.aoLvl != BUF_FULL;
				end
				REG_AI_LVL, REG_AI_DATA, REG_AO_LVL: ;
				default:     n.bresp = RESP_SLVERR;
			endcase
		end
		n.awready = !n.awDone && !n.bvalid;
		n.wready = !n.wDone && !n.bvalid;

		// read channel; a read of the data port pops one sample
		if (r.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (s_axi_arvalid && r.arready) begin
			n.rvalid = 1'b1;
			n.rresp = RESP_OKAY;
			n.rdata = '0;
			case (s_axi_araddr)
				REG_CTRL:    n.rdata = '0;
				REG_AI_CFG:  n.rdata = r.aiCfg;
				REG_AO_CFG:  n.rdata = r.aoCfg;
				REG_PIN_CFG: n.rdata = r.pinCfg;
				REG_AI_INTV: n.rdata = r.aiIntv;
				REG_AO_INTV: n.rdata = r.aoIntv;
				REG_AI_NUM:  n.rdata = r.aiNum;
				REG_AO_NUM:  n.rdata = r.aoNum;
				REG_STATUS: begin
					n.rdata[3:0] = r.flags;
					n.rdata[STAT_AI_BUSY] = r.aiSt != AI_IDLE;
					n.rdata[STAT_AO_BUSY] = r.aoSt != AO_IDLE;
				end
				REG_MASK:    n.rdata[3:0] = r.mask;
				REG_AI_LVL:  n.rdata[10:0] = r.aiLvl;
				REG_AO_LVL:  n.rdata[10:0] = r.aoLvl;
				REG_AI_DATA: begin
					// empty buffer reads zero and pops nothing
					aiPop = r.aiLvl != 11'h0;
					n.rdata[DATA_W-1:0] = aiPop ? aiMemRd : '0;
				end
				REG_AO_DATA: n.rdata = '0;
				default:     n.rresp = RESP_SLVERR;
			endcase
		end
		n.arready = !n.rvalid;

		// input path pacing: timer or external clock edge
		if (r.aiSt == AI_RUN || r.aiSt == AI_CONV) begin
			n.aiTmr = iacTimer(r.aiTmr, r.aiIntv);
			aiTick = r.aiCfg[CFG_SYNC] ? edg[PIN_AI_CLK] : (r.aiTmr == 32'h0);
		end
		aiStop = cmd[CMD_AI_STOP] || (edg[PIN_AI_STOP]
			&& r.aiCfg[CFG_STOP_LSB +: 2] == STOP_EXT);

		// input path sequence; ticks during a scan are ignored
		unique case (r.aiSt)
			AI_IDLE: begin
				if (cmd[CMD_AI_START]) begin
					n.aiSt = r.aiCfg[CFG_EXTSTART] ? AI_ARM : AI_RUN;
					n.aiTmr = r.aiIntv;
					n.aiCnt = '0;
				end
			end
			AI_ARM: begin
				if (aiStop) begin
					n.aiSt = AI_IDLE;
				end else if (edg[PIN_AI_START]) begin
					n.aiSt = AI_RUN;
				end
			end
			AI_RUN: begin
				if (aiStop) begin
					n.aiSt = AI_IDLE;
					fset[FLAG_AI_END] = 1'b1;
				end else if (aiTick) begin
					n.aiSt = AI_CONV;
					n.aiCh = '0;
					n.aiSlot = '0;
					n.adcChannel = '0;
					n.adcConvert = 1'b1;
				end
			end
			AI_CONV: begin
				n.aiSlot = 11'(r.aiSlot + 11'h1);
				if (aiStop) begin
					n.aiSt = AI_IDLE;
					fset[FLAG_AI_END] = 1'b1;
				end else if (r.aiSlot == CH_LAST) begin
					// sample ends its 10 us slot; overflow drops it
					aiPush = r.aiLvl != BUF_FULL;
					fset[FLAG_AI_OVF] = r.aiLvl == BUF_FULL;
					n.aiSlot = '0;
					if (r.aiCh == r.aiCfg[CFG_CHN_LSB +: 3]) begin
						n.aiCnt = 32'(r.aiCnt + 32'h1);
						if (iacCountDone(r.aiCfg, r.aiCnt, r.aiNum)) begin
							n.aiSt = AI_IDLE;
							fset[FLAG_AI_END] = 1'b1;
						end else begin
							n.aiSt = AI_RUN;
						end
					end else begin
						n.aiCh = 3'(r.aiCh + 3'h1);
						n.adcChannel = 3'(r.aiCh + 3'h1);
						n.adcConvert = 1'b1;
					end
				end
			end
		endcase

		// output path pacing and 10 us update holdoff
		if (r.aoHold != 11'h0) begin
			n.aoHold = 11'(r.aoHold - 11'h1);
		end
		if (r.aoSt != AO_IDLE && r.aoSt != AO_ARM) begin
			n.aoTmr = iacTimer(r.aoTmr, r.aoIntv);
			aoTick = r.aoCfg[CFG_SYNC] ? edg[PIN_AO_CLK] : (r.aoTmr == 32'h0);
		end
		aoStop = cmd[CMD_AO_STOP] || (edg[PIN_AO_STOP]
			&& r.aoCfg[CFG_STOP_LSB +: 2] == STOP_EXT);

		// output path sequence; a started channel pair always completes
		unique case (r.aoSt)
			AO_IDLE: begin
				if (cmd[CMD_AO_START]) begin
					n.aoSt = r.aoCfg[CFG_EXTSTART] ? AO_ARM : AO_RUN;
					n.aoTmr = r.aoIntv;
					n.aoCnt = '0;
				end
			end
			AO_ARM: begin
				if (aoStop) begin
					n.aoSt = AO_IDLE;
				end else if (edg[PIN_AO_START]) begin
					n.aoSt = AO_RUN;
				end
			end
			AO_RUN: begin
				if (aoStop) begin
					n.aoSt = AO_IDLE;
					fset[FLAG_AO_END] = 1'b1;
				end else if (aoTick && r.aoHold == 11'h0) begin
					if (r.aoLvl < AO_PAIR) begin
						n.aoSt = AO_IDLE;
						fset[FLAG_AO_UNF] = 1'b1;
						fset[FLAG_AO_END] = 1'b1;
					end else begin
						n.aoSt = AO_CH0;
					end
				end
			end
			AO_CH0: begin
				n.dacData = aoMemRd;
				n.dacChannel = 1'b0;
				n.dacLoad = 1'b1;
				n.aoHold = CH_LAST;
				aoPop = 1'b1;
				n.aoSt = AO_GAP;
			end
			AO_GAP: n.aoSt = AO_CH1; // read data follows the new pointer
			AO_CH1: begin
				n.dacData = aoMemRd;
				n.dacChannel = 1'b1;
				n.dacLoad = 1'b1;
				aoPop = 1'b1;
				n.aoCnt = 32'(r.aoCnt + 32'h1);
				if (iacCountDone(r.aoCfg, r.aoCnt, r.aoNum)) begin
					n.aoSt = AO_IDLE;
					fset[FLAG_AO_END] = 1'b1;
				end else begin
					n.aoSt = AO_RUN;
				end
			end
			default: n.aoSt = AO_IDLE;
		endcase

		// buffer pointers and levels
		n.aiWp = BUF_AW'(r.aiWp + {9'h0, aiPush});
		n.aiRp = BUF_AW'(r.aiRp + {9'h0, aiPop});
		n.aiLvl = 11'(r.aiLvl + {10'h0, aiPush} - {10'h0, aiPop});
		n.aoWp = BUF_AW'(r.aoWp + {9'h0, aoPush});
		n.aoRp = BUF_AW'(r.aoRp + {9'h0, aoPop});
		n.aoLvl = 11'(r.aoLvl + {10'h0, aoPush} - {10'h0, aoPop});

		// sticky flags: a new event wins over a clear in the same cycle
		n.flags = (r.flags & ~clr) | fset;
		n.irq = |(n.flags & n.mask);
	end

	// the one state register
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// outputs straight from the state register
	assign s_axi_awready = r.awready;
	assign s_axi_wready  = r.wready;
	assign s_axi_bresp   = r.bresp;
	assign s_axi_bvalid  = r.bvalid;
	assign s_axi_arready = r.arready;
	assign s_axi_rdata   = r.rdata;
	assign s_axi_rresp   = r.rresp;
	assign s_axi_rvalid  = r.rvalid;
	assign adcConvert    = r.adcConvert;
	assign adcChannel    = r.adcChannel;
	assign dacLoad       = r.dacLoad;
	assign dacChannel    = r.dacChannel;
	assign dacData       = r.dacData;
	assign intaReq       = r.irq;
endmodule : iac_sequencer
`default_nettype wire

// file: sim/iac_adc_model.sv
// behavioural input converter facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module iac_adc_model
	import iac_pkg::*;
(
	// clock and reset
	input  wire logic                       core_clk,
	input  wire logic                       reset,
	// converter control and data
	input  wire logic                       adcConvert,
	input  wire logic [2:0]                 adcChannel,
	output logic      [iac_pkg::DATA_W-1:0] adcData
);
	logic [11:0] slot_reg;
	// position within a slot, counting on past its end and saturating at 12'hFFF
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			slot_reg <= 12'hFFF;
		end else if (adcConvert) begin
			slot_reg <= 12'h000;
		end else if (slot_reg != 12'hFFF) begin
			slot_reg <= slot_reg + 12'h001;
		end
	end
	// outside a slot the value drifts so a mistimed sample is caught
	assign adcData = (slot_reg < 12'(CH_CYC)) ? {13'h1400, adcChannel} : {4'h5, slot_reg};
endmodule : iac_adc_model
`default_nettype wire

// file: sim/iac_sequencer_asserts.sv
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module iac_sequencer_asserts
	import iac_pkg::*;
(
	// clock and reset
	input wire logic                       core_clk,
	input wire logic                       reset,
	// bus handshakes
	input wire logic                       s_axi_awready,
	input wire logic                       s_axi_wready,
	input wire logic                       s_axi_bvalid,
	input wire logic                       s_axi_bready,
	input wire logic                       s_axi_arready,
	input wire logic                       s_axi_rvalid,
	input wire logic                       s_axi_rready,
	// converters
	input wire logic                       adcConvert,
	input wire logic [2:0]                 adcChannel,
	input wire logic                       dacLoad,
	input wire logic                       dacChannel,
	input wire logic [iac_pkg::DATA_W-1:0] dacData
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	logic [11:0] aiGap_reg;
	logic [11:0] aoGap_reg;
	// cycles since last pulse; saturates so the first pulse after reset passes
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			aiGap_reg <= 12'hFFF;
			aoGap_reg <= 12'hFFF;
		end else begin
			aiGap_reg <= adcConvert ? 12'h000 : aiGap_reg + 12'(aiGap_reg != 12'hFFF);
			aoGap_reg <= (dacLoad && !dacChannel) ? 12'h000 : aoGap_reg + 12'(aoGap_reg != 12'hFFF);
		end
	end

	sequence s_ch0;
		dacLoad && !dacChannel;
	endsequence
	sequence s_ch1;
		dacLoad && dacChannel;
	endsequence

	property p_adcPulse;
		adcConvert |=> !adcConvert;
	endproperty
	a_adcPulse: assert property (p_adcPulse) else $error("convert pulse too long");
	property p_adcGap;
		adcConvert |-> aiGap_reg >= {1'b0, CH_LAST};
	endproperty
	a_adcGap: assert property (p_adcGap) else $error("channel slot too short");
	property p_adcOrder;
		adcConvert && adcChannel != 3'h0 |-> adcChannel == $past(adcChannel) + 3'h1;
	endproperty
	a_adcOrder: assert property (p_adcOrder) else $error("channel order broken");
	property p_dacPair;
		s_ch0 |-> ##2 s_ch1;
	endproperty
	a_dacPair: assert property (p_dacPair) else $error("second output not loaded");
	property p_dacGap;
		s_ch0 |-> aoGap_reg >= {1'b0, CH_LAST};
	endproperty
	a_dacGap: assert property (p_dacGap) else $error("output updated too soon");
	property p_dacHold;
		!dacLoad |-> $stable(dacData) && $stable(dacChannel);
	endproperty
	a_dacHold: assert property (p_dacHold) else $error("output code moved");
	property p_wrBusy;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_wrBusy: assert property (p_wrBusy) else $error("write taken during response");
	property p_bDone;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready;
	endproperty
	a_bDone: assert property (p_bDone) else $error("write response not closed");
	property p_rDone;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
	endproperty
	a_rDone: assert property (p_rDone) else $error("read response not closed");
endmodule : iac_sequencer_asserts

bind iac_sequencer iac_sequencer_asserts u_chk (.*);
`default_nettype wire

// file: sim/tb_top.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import iac_pkg::*;
	// clock, reset and bus
	logic        core_clk, reset;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdVal;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	// pins and converters
	logic        aiStartPin, aiStopPin, aiClkPin, aoStartPin, aoStopPin, aoClkPin;
	logic        adcConvert, dacLoad, dacChannel, intaReq;
	logic [2:0]  adcChannel;
	logic [15:0] adcData, dacData;
	int          fail_count, samples_checked, cycles;

	iac_sequencer DUT (.*);
	iac_adc_model u_adc (.core_clk(core_clk), .reset(reset), .adcConvert(adcConvert),
		.adcChannel(adcChannel), .adcData(adcData));

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// hang guard, well above the few thousand cycles the run needs
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 40000) begin
			fail_count++;
			complete_run();
		end
	end

	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge core_clk);
			if (s_axi_awready === 1'b1 && !ad) begin
				ad = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready === 1'b1 && !wd) begin
				wd = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge core_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
		rdVal = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd

	// poll status until a flag shows; the hang guard bounds it
	task automatic waitFlag(input int b);
		rdVal = 32'h0;
		while (rdVal[b] !== 1'b1) rd(REG_STATUS);
	endtask : waitFlag

	task automatic t_regs;
		rd(REG_AI_CFG);
		chk(rdVal, 32'h0);
		rd(REG_STATUS);
		chk(rdVal, 32'h0);
		rd(8'h3C);
		chk(32'(resp), 32'(RESP_SLVERR));
		wr(8'h3C, 32'h1, 4'hF);
		chk(32'(resp), 32'(RESP_SLVERR));
	endtask : t_regs

	task automatic t_ao;
		wr(REG_AO_DATA, 32'h1234, 4'hF);
		wr(REG_AO_DATA, 32'hABCD, 4'hF);
		rd(REG_AO_LVL);
		chk(rdVal, 32'h2);
		wr(REG_AO_INTV, 32'hA, 4'hF);
		wr(REG_AO_NUM, 32'h1, 4'hF);
		wr(REG_CTRL, 32'h4, 4'h2);
		rd(REG_STATUS);
		chk(rdVal, 32'h0);
		wr(REG_CTRL, 32'h4, 4'h1);
		while (dacLoad !== 1'b1) @(posedge core_clk);
		chk({14'h0, dacLoad, dacChannel, dacData}, 32'h0002_1234);
		repeat (2) @(posedge core_clk);
		chk({14'h0, dacLoad, dacChannel, dacData}, 32'h0003_ABCD);
		waitFlag(FLAG_AO_END);
		chk(rdVal, 32'h8);
	endtask : t_ao

	task automatic t_unf;
		wr(REG_MASK, 32'h2, 4'hF);
		wr(REG_CTRL, 32'h4, 4'h1);
		waitFlag(FLAG_AO_UNF);
		chk(rdVal & 32'hF, 32'hA);
		chk(32'(intaReq), 32'h1);
		wr(REG_STATUS, 32'h2, 4'hF);
		repeat (2) @(posedge core_clk);
		chk(32'(intaReq), 32'h0);
		rd(REG_STATUS);
		chk(rdVal & 32'hF, 32'h8);
	endtask : t_unf

	task automatic t_ai;
		wr(REG_PIN_CFG, 32'h1, 4'hF);
		wr(REG_AI_CFG, 32'h12, 4'hF);
		wr(REG_AI_NUM, 32'h1, 4'hF);
		wr(REG_AI_INTV, 32'h13, 4'hF);
		wr(REG_CTRL, 32'h1, 4'h1);
		aiStartPin <= 1'b0;
		while (adcConvert !== 1'b1) @(posedge core_clk);
		chk(32'(adcChannel), 32'h0);
		waitFlag(FLAG_AI_END);
		rd(REG_AI_LVL);
		chk(rdVal, 32'h2);
		rd(REG_AI_DATA);
		chk(rdVal, 32'hA000);
		rd(REG_AI_DATA);
		chk(rdVal, 32'hA001);
		rd(REG_AI_DATA);
		chk(rdVal, 32'h0);
	endtask : t_ai

	// clock-pin pacing with filter on, then an external stop aborts the scan
	task automatic t_sync;
		int hits;
		hits = 0;
		wr(REG_STATUS, 32'h4, 4'h1);
		wr(REG_PIN_CFG, 32'h400, 4'hF);
		wr(REG_AI_CFG, 32'h5, 4'hF);
		wr(REG_CTRL, 32'h1, 4'h1);
		aiClkPin <= 1'b1;
		repeat (20) @(posedge core_clk);
		aiClkPin <= 1'b0;
		repeat (300) begin
			@(posedge core_clk);
			if (adcConvert === 1'b1) hits++;
		end
		chk(32'(hits), 32'h0);
		aiClkPin <= 1'b1;
		repeat (400) begin
			@(posedge core_clk);
			if (adcConvert === 1'b1) hits++;
		end
		chk(32'(hits), 32'h1);
		aiStopPin <= 1'b1;
		repeat (10) @(posedge core_clk);
		rd(REG_STATUS);
		chk(rdVal & 32'h104, 32'h4);
		rd(REG_AI_LVL);
		chk(rdVal, 32'h0);
	endtask : t_sync

	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{aiStopPin, aiClkPin, aoStartPin, aoStopPin, aoClkPin} = '0;
		aiStartPin = 1'b1;
		reset = 1'b1;
		repeat (10) @(posedge core_clk);
		reset <= 1'b0;
		t_regs();
		t_ao();
		t_unf();
		t_ai();
		t_sync();
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
